// >>> bdp_drive_ctrl.sv
// Contract
// R1 - peak current hit cuts output on-time
// R2 - limited chop restarts on oscillator period
// R3 - oscillator clocks logic, always running
// R4 - stop mode enters power save
// R5 - direction reverses sequence, no shoot-through
// R6 - after reversal at limit: low off, short-brake
// R7 - brake request low short-brakes windings
// R8 - braking suspends current limit and lock
// R9 - no hall edge in period latches lows off
// R10 - lock period 0.35 s per microfarad
// R11 - lock clears: stop, zero duty, power-up
// R12 - grounded timer capacitor disables lock
// R13 - host waits before restart after lock
// R14 - undervoltage turns lows off, hysteretic release
// R15 - open-collector composite hall output
// R16 - run_stop low runs, high stops
// R17 - duty_pulse_in low enables drive
// R18 - duty modulation applied on low side
// R19 - all halls common-mode turns everything off
// R20 - inputs synchronised, hall change restarts timer
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bdp_drive_ctrl #(
  parameter int LOCK_CYC_PER_UF = bdp_pkg::LOCK_CYC_PER_UF,
  parameter int LSW = $clog2(LOCK_CYC_PER_UF + 1)
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control pins
  input wire logic run_stop,
  input wire logic brake_request,
  input wire logic duty_pulse_in,
  input wire logic direction_select,
  input wire logic duty_level_zero,
  // hall inputs
  input wire logic hall_a_pos,
  input wire logic hall_b_pos,
  input wire logic hall_c_pos,
  input wire logic hall_all_common,
  // forward commutation request per phase
  input wire logic [2:0] commut_high,
  input wire logic [2:0] commut_low,
  // analog comparator results
  input wire logic current_limit_hit,
  input wire logic vcc_below_trip,
  input wire logic vcc_above_release,
  input wire logic lock_cap_grounded,
  // output switches
  output logic [2:0] low_drive,
  output logic [2:0] high_drive,
  // open-collector composite hall
  output logic hall_comp_o,
  output logic hall_comp_oe,
  // status
  output logic power_save,
  output logic lock_active,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  typedef struct packed {
    logic [bdp_pkg::SI_N-1:0] sync1;
    logic [bdp_pkg::SI_N-1:0] sync2;
    logic [2:0] hall_prev;
    logic dir_prev;
    logic [15:0] osc_period;
    logic [7:0] lock_cap;
    logic [7:0] dead_cfg;
    logic cl_q;
    logic uv_q;
    logic lock_q;
    logic dir_hold;
    logic [7:0] dead_cnt;
    logic [LSW-1:0] lock_sub;
    logic [7:0] lock_units;
    logic [3:0] zero_cnt;
    bdp_pkg::bdp_mode_t mode;
    logic [2:0] low;
    logic [2:0] high;
    logic hp_o;
    logic hp_oe;
    logic psave;
    logic wait_q;
    logic [31:0] rdata;
  } bdp_st_t;

  bdp_st_t s, n;
  logic [1:0] rst_q;
  logic rst_n;
  logic tick;
  logic [bdp_pkg::SI_N-1:0] raw;
  // idle levels: stop, no brake and duty off high, every sense flag low
  localparam int SN = bdp_pkg::SI_N;
  localparam logic [SN-1:0] SYNC_IDLE = SN'((1 << bdp_pkg::SI_RUN) | (1 << bdp_pkg::SI_BRK)
    | (1 << bdp_pkg::SI_PWM));

  // reset released through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // oscillator period tick that times chopping and zero duty
  bdp_osc_tick #(
    .W(16)
  ) u_osc (
    .clk(clk),
    .rst_n(rst_n),
    .period(s.osc_period),
    .tick(tick)
  ); // R3

  // raw inputs gathered for synchronisation
  assign raw = {lock_cap_grounded, vcc_above_release, vcc_below_trip,
                duty_level_zero, current_limit_hit, hall_all_common,
                hall_c_pos, hall_b_pos, hall_a_pos, direction_select,
                duty_pulse_in, brake_request, run_stop};

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // next-state logic
  always_comb begin
    logic run;
    logic brk;
    logic pwm_on;
    logic [2:0] hall;
    logic hall_chg;
    logic dir;
    logic dir_chg;
    logic hit;
    logic duty0;
    logic lock_en;
    logic lock_set;
    logic lock_clr;
    logic req;
    logic [2:0] sel_h;
    logic [2:0] sel_l;
    logic [31:0] stat;
    logic [31:0] rmux;
    bdp_pkg::bdp_mode_t m;

    n = s;
    rmux = 32'h0000_0000;
    n.sync1 = raw; // R20
    n.sync2 = s.sync1; // R20

    run = ~s.sync2[bdp_pkg::SI_RUN]; // R16
    brk = ~s.sync2[bdp_pkg::SI_BRK]; // R7
    pwm_on = ~s.sync2[bdp_pkg::SI_PWM]; // R17
    dir = s.sync2[bdp_pkg::SI_DIR];
    hall = s.sync2[bdp_pkg::SI_HC:bdp_pkg::SI_HA];
    hit = s.sync2[bdp_pkg::SI_CL];
    hall_chg = hall != s.hall_prev;
    dir_chg = dir != s.dir_prev;
    n.hall_prev = hall;
    n.dir_prev = dir;

    // peak current latch, released on the next oscillator period
    if (brk) begin
      n.cl_q = 1'b0; // R8
    end else if (hit) begin
      n.cl_q = 1'b1; // R1
    end else if (tick) begin
      n.cl_q = 1'b0; // R2
    end

    // undervoltage with hysteresis
    if (s.sync2[bdp_pkg::SI_UVT]) begin
      n.uv_q = 1'b1; // R14
    end else if (s.sync2[bdp_pkg::SI_UVR]) begin
      n.uv_q = 1'b0; // R14
    end

    // direction change: dead time, then short-brake while at limit
    if (dir_chg && run) begin
      n.dead_cnt = s.dead_cfg; // R5
      n.dir_hold = 1'b1; // R6
    end else begin
      if (s.dead_cnt != 8'h00) begin
        n.dead_cnt = s.dead_cnt - 8'h01;
      end
      if (!run || (tick && !hit && s.dead_cnt == 8'h00)) begin
        n.dir_hold = 1'b0; // R6
      end
    end

    // zero-duty period counter
    duty0 = ~pwm_on | s.sync2[bdp_pkg::SI_DZ];
    if (!duty0) begin
      n.zero_cnt = 4'h0;
    end else if (tick && s.zero_cnt <= bdp_pkg::DUTY_ZERO_PERIODS) begin
      n.zero_cnt = s.zero_cnt + 4'h1;
    end

    // lock timer, restarted by any hall change
    lock_en = run && !brk && !s.sync2[bdp_pkg::SI_GND]; // R8 R12
    lock_set = 1'b0;
    if (!lock_en || hall_chg || s.lock_q) begin
      n.lock_sub = '0; // R20
      n.lock_units = 8'h00;
    end else if (s.lock_sub == LSW'(LOCK_CYC_PER_UF - 1)) begin
      n.lock_sub = '0;
      n.lock_units = s.lock_units + 8'h01; // R10
      if (s.lock_units + 8'h01 >= s.lock_cap) begin
        lock_set = 1'b1; // R9
      end
    end else begin
      n.lock_sub = s.lock_sub + LSW'(1);
    end
    if (s.lock_cap == 8'h00) begin
      lock_set = 1'b0; // R12
    end
    lock_clr = !run || (s.zero_cnt > bdp_pkg::DUTY_ZERO_PERIODS); // R11
    if (lock_set) begin
      n.lock_q = 1'b1; // R9
    end else if (lock_clr) begin
      n.lock_q = 1'b0; // R11
    end

    // reversed direction swaps source and sink phases
    sel_h = dir ? commut_low : commut_high; // R5
    sel_l = dir ? commut_high : commut_low; // R5

    // mode in priority order
    if (!run) begin
      m = bdp_pkg::MODE_STOP; // R16
    end else if (s.sync2[bdp_pkg::SI_CM]) begin
      m = bdp_pkg::MODE_OFF; // R19
    end else if (brk) begin
      m = bdp_pkg::MODE_BRAKE; // R7
    end else if (s.uv_q) begin
      m = bdp_pkg::MODE_UV; // R14
    end else if (s.lock_q || lock_set) begin
      m = bdp_pkg::MODE_LOCK; // R9
    end else if (s.dead_cnt != 8'h00) begin
      m = bdp_pkg::MODE_DEAD; // R5
    end else if (s.dir_hold && (hit || s.cl_q)) begin
      m = bdp_pkg::MODE_DIRBRK; // R6
    end else begin
      m = bdp_pkg::MODE_DRIVE;
    end
    n.mode = m;

    // output switches per mode
    case (m)
      bdp_pkg::MODE_BRAKE, bdp_pkg::MODE_DIRBRK: begin
        n.high = bdp_pkg::PH_ON; // R7 R6
        n.low = bdp_pkg::PH_OFF;
      end
      bdp_pkg::MODE_UV, bdp_pkg::MODE_LOCK: begin
        n.high = sel_h;
        n.low = bdp_pkg::PH_OFF; // R14 R9
      end
      bdp_pkg::MODE_DRIVE: begin
        n.high = sel_h;
        n.low = (pwm_on && !s.cl_q && !hit) ? (sel_l & ~sel_h) : bdp_pkg::PH_OFF; // R18 R1 R5
      end
      default: begin
        n.high = bdp_pkg::PH_OFF; // R19 R5
        n.low = bdp_pkg::PH_OFF;
      end
    endcase

    // composite hall, pulled low while the parity is low
    n.hp_o = 1'b0;
    n.hp_oe = ~^hall; // R15
    n.psave = !run; // R4

    // status word
    stat = 32'h0000_0000;
    stat[bdp_pkg::ST_LOCK] = s.lock_q;
    stat[bdp_pkg::ST_UV] = s.uv_q;
    stat[bdp_pkg::ST_PSAVE] = s.psave;
    stat[bdp_pkg::ST_CL] = s.cl_q;
    stat[bdp_pkg::ST_DIRHOLD] = s.dir_hold;
    stat[bdp_pkg::ST_HALL +: 3] = hall;
    stat[bdp_pkg::ST_MODE +: 3] = s.mode;

    // register read mux, unmapped reads as zero
    case (avs_address)
      bdp_pkg::ADDR_OSC: rmux = {16'h0000, s.osc_period};
      bdp_pkg::ADDR_LOCK: rmux = {24'h000000, s.lock_cap};
      bdp_pkg::ADDR_STAT: rmux = stat;
      bdp_pkg::ADDR_DEAD: rmux = {24'h000000, s.dead_cfg};
      default: rmux = 32'h0000_0000;
    endcase

    // bus slave: one wait cycle, then completion
    req = avs_read | avs_write;
    n.wait_q = !(req && s.wait_q);
    if (avs_read && s.wait_q) begin
      n.rdata = rmux;
    end
    if (avs_write && !s.wait_q) begin
      case (avs_address)
        bdp_pkg::ADDR_OSC: begin
          n.osc_period = 16'(merge({16'h0000, s.osc_period},
                                   avs_writedata, avs_byteenable));
        end
        bdp_pkg::ADDR_LOCK: begin
          n.lock_cap = 8'(merge({24'h000000, s.lock_cap},
                                avs_writedata, avs_byteenable));
        end
        bdp_pkg::ADDR_DEAD: begin
          n.dead_cfg = 8'(merge({24'h000000, s.dead_cfg},
                                avs_writedata, avs_byteenable));
        end
        default: begin
          n.rdata = s.rdata;
        end
      endcase
    end
  end

  // state register, reset to stop with outputs off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.sync1 <= SYNC_IDLE;
      s.sync2 <= SYNC_IDLE;
      s.hall_prev <= 3'h7;
      s.dir_prev <= 1'b1;
      s.osc_period <= bdp_pkg::OSC_PERIOD_RST;
      s.lock_cap <= bdp_pkg::LOCK_CAP_RST;
      s.dead_cfg <= bdp_pkg::DEAD_RST;
      s.mode <= bdp_pkg::MODE_STOP;
      s.psave <= 1'b1;
      s.wait_q <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign low_drive = s.low;
  assign high_drive = s.high;
  assign hall_comp_o = s.hp_o;
  assign hall_comp_oe = s.hp_oe;
  assign power_save = s.psave;
  assign lock_active = s.lock_q;
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.wait_q;
endmodule // bdp_drive_ctrl
`default_nettype wire

// >>> bdp_drive_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
// pin level checks on the drive controller
module bdp_drive_ctrl_chk (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control and sense inputs
  input wire logic run_stop,
  input wire logic brake_request,
  input wire logic duty_pulse_in,
  input wire logic hall_a_pos,
  input wire logic hall_b_pos,
  input wire logic hall_c_pos,
  input wire logic hall_all_common,
  input wire logic current_limit_hit,
  input wire logic vcc_below_trip,
  // switch and status outputs
  input wire logic [2:0] low_drive,
  input wire logic [2:0] high_drive,
  input wire logic hall_comp_o,
  input wire logic hall_comp_oe,
  input wire logic power_save,
  input wire logic lock_active,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // inputs count once held across both sync stages
  AST_STOP_OFF: assert property ($past(run_stop, 3) && $past(run_stop, 4)
    |-> power_save && !lock_active && low_drive == 3'h0 && high_drive == 3'h0)
    else $error("stop did not idle the switches");
  AST_COMMON_OFF: assert property (!$past(run_stop, 3) && $past(hall_all_common, 3)
    && $past(hall_all_common, 4) |-> low_drive == 3'h0 && high_drive == 3'h0)
    else $error("common mode halls left a switch on");
  AST_BRAKE: assert property (!$past(run_stop, 3) && !$past(hall_all_common, 3)
    && !$past(brake_request, 3) && !$past(brake_request, 4)
    |-> high_drive == bdp_pkg::PH_ON && low_drive == bdp_pkg::PH_OFF)
    else $error("brake not a short brake");
  AST_PWM_OFF: assert property ($past(duty_pulse_in, 3) && $past(duty_pulse_in, 4)
    |-> low_drive == 3'h0)
    else $error("low side on while duty input high");
  AST_LIMIT: assert property ($past(current_limit_hit, 3) && $past(current_limit_hit, 4)
    |-> low_drive == 3'h0)
    else $error("low side on at current limit");
  AST_UV: assert property ($past(vcc_below_trip, 3) && $past(vcc_below_trip, 4)
    |-> low_drive == 3'h0)
    else $error("low side on in undervoltage");
  AST_NO_SHOOT: assert property ((low_drive & high_drive) == 3'h0)
    else $error("high and low side on in one phase");
  AST_LOCK_LOW: assert property (lock_active |-> low_drive == 3'h0)
    else $error("low side on while locked");
  AST_HALL_OC: assert property ($past(arst_n, 6) |-> !hall_comp_o
    && hall_comp_oe == !($past(hall_a_pos, 3) ^ $past(hall_b_pos, 3) ^ $past(hall_c_pos, 3)))
    else $error("composite hall output wrong");
  AST_BUS_ACK: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
endmodule // bdp_drive_ctrl_chk
`default_nettype wire

// >>> bdp_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
// motor with hall sensors and its commutation table
module bdp_motor_model (
  // clock and rotor control
  input wire logic clk,
  input wire logic spin,
  // hall sensors
  output logic hall_a_pos,
  output logic hall_b_pos,
  output logic hall_c_pos,
  // forward commutation request
  output logic [2:0] commut_high,
  output logic [2:0] commut_low
);
  localparam logic [17:0] HALL_SEQ = 18'({3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5});
  logic [2:0] pos = 3'h0;
  logic [4:0] t = 5'h0;
  // rotor steps one hall state every 32 cycles, stands still when stalled
  always @(posedge clk) begin
    if (spin) begin
      t <= t + 5'h1;
      if (t == 5'h1F) pos <= (pos == 3'h5) ? 3'h0 : pos + 3'h1;
    end
  end
  // one high and one other low phase, never the same one
  assign {hall_c_pos, hall_b_pos, hall_a_pos} = HALL_SEQ[pos*3 +: 3];
  assign commut_high = 3'h1 << (pos % 3'h3);
  assign commut_low = 3'h1 << ((pos + 3'h1) % 3'h3);
endmodule // bdp_motor_model
`default_nettype wire

// >>> bdp_osc_tick.sv
`timescale 1ns/1ps
`default_nettype none
module bdp_osc_tick #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // period in clock cycles
  input wire logic [W-1:0] period,
  // one-cycle pulse per oscillator period
  output logic tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } bdp_osc_st_t;

  bdp_osc_st_t s, n;

  // free-running counter, never gated by stop mode
  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (s.cnt + W'(1) >= period) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;
endmodule // bdp_osc_tick
`default_nettype wire

// >>> bdp_pkg.sv
`default_nettype none
package bdp_pkg;
  // clock and oscillator timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_NS = 20;
  localparam int OSC_HZ = 20_000;
  localparam logic [15:0] OSC_PERIOD_RST = 16'(CLK_HZ / OSC_HZ);
  // lock period per microfarad of timer capacitance
  localparam int LOCK_NS_PER_UF = 350_000_000;
  localparam int LOCK_CYC_PER_UF = LOCK_NS_PER_UF / CLK_NS;
  localparam logic [7:0] LOCK_CAP_RST = 8'h0A;
  // dead time on a direction change, least time so rounded up
  localparam int DEAD_NS = 2_000;
  localparam logic [7:0] DEAD_RST = 8'((DEAD_NS + CLK_NS - 1) / CLK_NS);
  // oscillator periods of zero duty that must be exceeded to clear a lock
  localparam logic [3:0] DUTY_ZERO_PERIODS = 4'h8;
  // register byte addresses
  localparam logic [3:0] ADDR_OSC = 4'h0;
  localparam logic [3:0] ADDR_LOCK = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_DEAD = 4'hC;
  // status field positions
  localparam int ST_LOCK = 0;
  localparam int ST_UV = 1;
  localparam int ST_PSAVE = 2;
  localparam int ST_CL = 3;
  localparam int ST_DIRHOLD = 4;
  localparam int ST_HALL = 8;
  localparam int ST_MODE = 12;
  // synchroniser bit positions
  localparam int SI_RUN = 0;
  localparam int SI_BRK = 1;
  localparam int SI_PWM = 2;
  localparam int SI_DIR = 3;
  localparam int SI_HA = 4;
  localparam int SI_HC = 6;
  localparam int SI_CM = 7;
  localparam int SI_CL = 8;
  localparam int SI_DZ = 9;
  localparam int SI_UVT = 10;
  localparam int SI_UVR = 11;
  localparam int SI_GND = 12;
  localparam int SI_N = 13;
  localparam logic [2:0] PH_OFF = 3'h0;
  localparam logic [2:0] PH_ON = 3'h7;
  // drive modes
  typedef enum logic [2:0] {
    MODE_STOP = 3'b000,
    MODE_DRIVE = 3'b001,
    MODE_BRAKE = 3'b010,
    MODE_LOCK = 3'b011,
    MODE_DEAD = 3'b100,
    MODE_DIRBRK = 3'b101,
    MODE_OFF = 3'b110,
    MODE_UV = 3'b111
  } bdp_mode_t;
endpackage
`default_nettype wire

// >>> test_bldc_drive_protection_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_bldc_drive_protection_control;
  localparam logic [31:0] FM = 32'hFFFFFFFF;
  logic clk = 1'b0, arst_n = 1'b0, spin = 1'b0, smp = 1'b0;
  logic run_stop = 1'b1, brake_request = 1'b1, duty_pulse_in = 1'b1, direction_select = 1'b0;
  logic duty_level_zero = 1'b0, hall_all_common = 1'b0, current_limit_hit = 1'b0;
  logic vcc_below_trip = 1'b0, vcc_above_release = 1'b0, lock_cap_grounded = 1'b0;
  logic hall_a_pos, hall_b_pos, hall_c_pos, hall_comp_o, hall_comp_oe, power_save, lock_active;
  logic [2:0] commut_high, commut_low, low_drive, high_drive;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, got, ex, mk, rnd = 32'h70C5;
  logic [31:0] q_e[$], q_m[$];
  int n_errors = 0, checked = 0, osc;
  // 50 MHz clock
  always #10 clk = ~clk;
  bdp_drive_ctrl #(.LOCK_CYC_PER_UF(50)) i_bdp_drive_ctrl (.clk, .arst_n, .run_stop,
    .brake_request, .duty_pulse_in, .direction_select, .duty_level_zero, .hall_a_pos,
    .hall_b_pos, .hall_c_pos, .hall_all_common, .commut_high, .commut_low, .current_limit_hit,
    .vcc_below_trip, .vcc_above_release, .lock_cap_grounded, .low_drive, .high_drive,
    .hall_comp_o, .hall_comp_oe, .power_save, .lock_active, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest);
  bdp_motor_model i_bdp_motor_model (.clk, .spin, .hall_a_pos, .hall_b_pos, .hall_c_pos,
    .commut_high, .commut_low);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk); // let an edge pass before any next request
    if (n >= 50) begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    q_e.push_back(e);
    q_m.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  // note the expected switch and status pins for the next edge
  task automatic pins(input logic [31:0] e, input logic [31:0] m);
    q_e.push_back(e);
    q_m.push_back(m);
    smp <= 1'b1;
    @(posedge clk);
    smp <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // take the oldest note whenever read data or a pin sample shows
  always @(posedge clk) begin
    if ((avs_read && !avs_waitrequest) || smp) begin
      got = smp ? {23'h0, lock_active, power_save, hall_comp_oe, high_drive, low_drive}
        : avs_readdata;
      ex = q_e.pop_front();
      mk = q_m.pop_front();
      checked++;
      if ((got & mk) !== (ex & mk)) begin
        n_errors++;
        $display("mismatch %s exp %h got %h", smp ? "pins" : "readdata", ex & mk, got & mk);
      end
    end
  end
  initial begin
    cyc(16);
    arst_n <= 1'b1;
    cyc(4);
    // defaults, an unmapped address and a random oscillator period
    rd(bdp_pkg::ADDR_OSC, 32'h9C4, FM);
    rd(bdp_pkg::ADDR_LOCK, 32'hA, FM);
    rd(bdp_pkg::ADDR_DEAD, 32'h64, FM);
    bus(1'b1, 4'h6, 32'h55);
    rd(4'h6, 32'h0, FM);
    rd(bdp_pkg::ADDR_LOCK, 32'hA, FM);
    rnd = xs(rnd);
    osc = 16 + int'(rnd[4:0]);
    bus(1'b1, bdp_pkg::ADDR_OSC, 32'(osc));
    rd(bdp_pkg::ADDR_OSC, 32'(osc), FM);
    pins(32'h80, 32'h1BF);
    rd(bdp_pkg::ADDR_STAT, 32'h4, 32'h7004);
    // run, duty off, current hit
    run_stop <= 1'b0;
    duty_pulse_in <= 1'b0;
    spin <= 1'b1;
    cyc(80);
    rd(bdp_pkg::ADDR_STAT, 32'h1000, 32'h7000);
    duty_pulse_in <= 1'b1;
    cyc(6);
    pins(32'h0, 32'h7);
    duty_pulse_in <= 1'b0;
    current_limit_hit <= 1'b1;
    cyc(6);
    pins(32'h0, 32'h7);
    rd(bdp_pkg::ADDR_STAT, 32'h1008, 32'h7008);
    current_limit_hit <= 1'b0;
    cyc(2 * osc + 10);
    rd(bdp_pkg::ADDR_STAT, 32'h1000, 32'h7008);
    // brake with a stalled rotor and a hit
    brake_request <= 1'b0;
    spin <= 1'b0;
    current_limit_hit <= 1'b1;
    cyc(6);
    pins(32'h38, 32'h13F);
    rd(bdp_pkg::ADDR_STAT, 32'h2000, 32'h7008);
    cyc(600);
    pins({25'h0, ~^{hall_a_pos, hall_b_pos, hall_c_pos}, 6'h38}, 32'h17F);
    current_limit_hit <= 1'b0;
    brake_request <= 1'b1;
    // stall lock after 10 x 50 cycles, cleared by zero duty
    cyc(400);
    pins(32'h0, 32'h100);
    cyc(150);
    pins(32'h100, 32'h107);
    rd(bdp_pkg::ADDR_STAT, 32'h3001, 32'h7001);
    duty_level_zero <= 1'b1;
    spin <= 1'b1;
    cyc(10 * osc + 20);
    pins(32'h0, 32'h100);
    duty_level_zero <= 1'b0;
    spin <= 1'b0;
    cyc(560);
    pins(32'h100, 32'h100);
    run_stop <= 1'b1;
    cyc(6);
    pins(32'h80, 32'h1BF);
    cyc(200);
    lock_cap_grounded <= 1'b1;
    run_stop <= 1'b0;
    cyc(700);
    pins(32'h0, 32'h100);
    lock_cap_grounded <= 1'b0;
    // undervoltage with hysteresis
    spin <= 1'b1;
    vcc_below_trip <= 1'b1;
    cyc(6);
    pins(32'h0, 32'h7);
    vcc_below_trip <= 1'b0;
    cyc(20);
    rd(bdp_pkg::ADDR_STAT, 32'h7002, 32'h7002);
    vcc_above_release <= 1'b1;
    cyc(6);
    vcc_above_release <= 1'b0;
    rd(bdp_pkg::ADDR_STAT, 32'h1000, 32'h7002);
    hall_all_common <= 1'b1;
    cyc(6);
    pins(32'h0, 32'h3F);
    rd(bdp_pkg::ADDR_STAT, 32'h6000, 32'h7000);
    hall_all_common <= 1'b0;
    // reversal at the limit: dead time, then short brake
    direction_select <= 1'b1;
    current_limit_hit <= 1'b1;
    cyc(6);
    rd(bdp_pkg::ADDR_STAT, 32'h4000, 32'h7000);
    cyc(120);
    pins(32'h38, 32'h3F);
    rd(bdp_pkg::ADDR_STAT, 32'h5000, 32'h7000);
    current_limit_hit <= 1'b0;
    cyc(3 * osc + 10);
    rd(bdp_pkg::ADDR_STAT, 32'h1000, 32'h7000);
    end_sim();
  end
endmodule // test_bldc_drive_protection_control
bind bdp_drive_ctrl bdp_drive_ctrl_chk i_bdp_drive_ctrl_chk (.clk, .arst_n, .run_stop,
  .brake_request, .duty_pulse_in, .hall_a_pos, .hall_b_pos, .hall_c_pos, .hall_all_common,
  .current_limit_hit, .vcc_below_trip, .low_drive, .high_drive, .hall_comp_o, .hall_comp_oe,
  .power_save, .lock_active, .avs_read, .avs_write, .avs_waitrequest);
`default_nettype wire
